// ===== common/gauge_defs.svh
// constants for the gauge host register bank
`ifndef GAUGE_DEFS_SVH
`define GAUGE_DEFS_SVH
`define A_TRIG     7'h00
`define A_MODE     7'h01
`define A_PRED     7'h02
`define A_PTTE     7'h04
`define A_TEMP     7'h06
`define A_VOLT     7'h08
`define A_FLAGS    7'h0a
`define A_RELATIVE_CHARGE_PCT     7'h0b
`define A_NAC      7'h0c
`define A_RATE_COMP_CAPACITY     7'h0e
`define A_THERMAL_COMP_CAPACITY     7'h10
`define A_LMD      7'h12
`define A_AVG      7'h14
`define A_TTE      7'h16
`define A_TTF      7'h18
`define A_SI       7'h1a
`define A_STANDBY_TIME_TO_EMPTY     7'h1c
`define A_MLI      7'h1e
`define A_MLTTE    7'h20
`define A_SAE      7'h22
`define A_LEARNING_AGE_COUNT     7'h28
`define A_LIFETIME_DISCHARGE_COUNT     7'h2a
`define KEY_CMD    8'ha9
`define KEY_CAL    8'h56
`define M_LOADAR   5
`define M_FULL     4
`define M_PARTIAL_RESET_CMD     3
`define M_POR      2
`define M_FULL_RESET_CMD     1
`define M_SHIP     0
`define M_CEO      5
`define M_CIO      4
`define M_CLRMASK  8'hc4
`define M_GPIO_IN  7
`define M_GPIO_LVL 6
`define MODE_RST   8'h04
`define F_CHARGING_STATE_BIT     7
`define F_CI       4
`define F_CAL      3
`define F_VDQ      2
`define F_FIRST_EMPTY_WARNING     1
`define F_FINAL_EMPTY     0
`define AGE_LIMIT  16'h0020
`define MIN_PER_H  32'd60
`define TAPER_MUL  32'd90
`define PCT_MUL    32'd100
`define SAT16      16'hffff
`endif

// ===== common/gauge_pkg.sv
// types shared by the gauge register bank
package gauge_pkg;
  typedef enum logic [2:0] {
    CMD_IDLE = 3'b001,
    CMD_EXEC = 3'b010,
    CMD_DONE = 3'b100
  } cmd_state_t;
  typedef enum logic [5:0] {
    OP_NONE  = 6'b000000,
    OP_LOAD  = 6'b000001,
    OP_FULL  = 6'b000010,
    OP_PARTIAL_RESET_CMD  = 6'b000100,
    OP_FULL_RESET_CMD  = 6'b001000,
    OP_SHIP  = 6'b010000,
    OP_CAL   = 6'b100000
  } cmd_op_t;
endpackage

// ===== hdl/gauge_host_register_bank.sv
// host register bank of a single cell fuel gauge
// Notes on behaviour
// RULE_01 - several command bits set: higher bit position wins, bit 5 highest.
// RULE_02 - key 0xa9 runs only the top command, then clears others and trigger.
// RULE_03 - host sets the mode bit first, then writes the key to trigger.
// RULE_04 - host may program internal minus external offset into pack config.
// RULE_05 - host predicted current only feeds predicted time to empty; the load command also copies it into nominal.
// RULE_06 - inaccurate flag set on full reset or 32 ages; cleared on learning.
// RULE_07 - calibrating flag high during any offset calibration; reset clears it.
// RULE_08 - valid discharge set when qualified; cleared on learn, disqualify, reset.
// RULE_09 - first empty flag at voltage below first threshold; learn on rise.
// RULE_10 - final empty flag at empty threshold; four flags clear on resets.
// RULE_11 - relative charge is 100 times nominal over learned capacity.
// RULE_12 - nominal counts up on charge above final threshold, down on discharge.
// RULE_13 - rate capacity equals nominal when charging, never rises discharging.
// RULE_14 - thermal capacity follows rate capacity, reduced below temp threshold.
// RULE_15 - learned capacity updates only at first empty with valid discharge.
// RULE_16 - average current is the 5.12 s average magnitude.
// RULE_17 - time to empty is 60 times thermal capacity over average current.
// RULE_18 - time to full is 90 times learned minus nominal over current.
// RULE_19 - standby filter: 15/16 old plus 1/16 average, inside the window.
// RULE_20 - standby time to empty is 60 times nominal over standby current.
// RULE_21 - learning age counts cycle increments, clears on learn, 32 sets flag.
// RULE_22 - trigger register clears once a key is accepted.
// RULE_23 - force full makes nominal equal learned capacity.
// RULE_24 - partial reset keeps nominal, learned and inaccurate flag.
// RULE_25 - zero divisor gives the maximum value.
`timescale 1ns/1ps
`include "gauge_defs.svh"
module gauge_host_register_bank (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic [6:0]  host_addr_i,
  input  wire logic        host_wr_i,
  input  wire logic [7:0]  host_wdata_i,
  output logic      [7:0]  host_rdata_o,
  input  wire logic        avg_tick_i,
  input  wire logic [15:0] avg_current_i,
  input  wire logic [15:0] temperature_i,
  input  wire logic [15:0] cell_voltage_pin_i,
  input  wire logic [15:0] first_thresh_i,
  input  wire logic [15:0] final_thresh_i,
  input  wire logic        charging_state_bit_i,
  input  wire logic        charge_count_i,
  input  wire logic        discharge_count_i,
  input  wire logic [15:0] rate_comp_new_i,
  input  wire logic        temp_below_i,
  input  wire logic [3:0]  temp_gain_i,
  input  wire logic [7:0]  temp_deficit_i,
  input  wire logic [7:0]  initial_design_capacity_i,
  input  wire logic [15:0] initial_standby_i,
  input  wire logic [3:0]  magnitude_filter_threshold_i,
  input  wire logic        learn_qualified_i,
  input  wire logic        learn_disqualify_i,
  input  wire logic [15:0] measured_capacity_i,
  input  wire logic        cycle_inc_i,
  input  wire logic        auto_cal_i,
  input  wire logic        cal_done_i,
  input  wire logic        ram_corrupt_i,
  input  wire logic [15:0] max_load_current_i,
  input  wire logic [15:0] max_load_tte_i,
  input  wire logic [15:0] available_energy_i,
  output logic             cal_start_o,
  output logic             external_offset_measure_o,
  output logic             ship_request_o,
  output logic             gpio_input_mode_o,
  output logic             gpio_level_o
);
  import gauge_pkg::*;
  // ***************************************
  // helpers
  // ***************************************
  // saturating divide, zero divisor reads as maximum
  function automatic logic [15:0] div_sat(input logic [31:0] n,
                                          input logic [15:0] d);
    logic [31:0] q;
    q = 32'h0;
    if (d == 16'h0) begin
      div_sat = `SAT16; // RULE_25
    end else begin
      q = n / {16'h0, d};
      div_sat = (q[31:16] != 16'h0) ? `SAT16 : q[15:0];
    end
  endfunction
  // byte select of a 16 bit register pair
  function automatic logic [7:0] pick(input logic [15:0] v,
                                      input logic hi);
    pick = hi ? v[15:8] : v[7:0];
  endfunction
  // ***************************************
  // state
  // ***************************************
  cmd_state_t  state_reg, state_next;
  cmd_op_t     op_reg, op_sel;
  logic [7:0]  trig_reg, mode_reg, pct_reg;
  logic [15:0] pred_reg, ptte_reg, temp_reg, volt_reg, nac_reg;
  logic [15:0] rate_comp_capacity_reg, thermal_comp_capacity_reg, lmd_reg, avg_reg, tte_reg;
  logic [15:0] ttf_reg, si_reg, standby_time_to_empty_reg, mli_reg, mltte_reg, sae_reg;
  logic [15:0] age_reg, life_reg;
  logic        ci_reg, cal_reg, vdq_reg, first_empty_warning_reg, final_empty_reg;
  logic        init_reg;
  // ***************************************
  // command decode
  // ***************************************
  wire key_cmd  = host_wr_i && host_addr_i == `A_TRIG &&
                  host_wdata_i == `KEY_CMD;
  wire key_cal  = host_wr_i && host_addr_i == `A_TRIG &&
                  host_wdata_i == `KEY_CAL;
  wire take_key = (state_reg == CMD_IDLE) && (key_cmd || key_cal);
  wire cal_req  = mode_reg[`M_CEO] || mode_reg[`M_CIO];
  // calibration key selects calibration, else highest set bit wins
  always_comb begin
    op_sel = OP_NONE;
    if (key_cal) begin
      op_sel = cal_req ? OP_CAL : OP_NONE;
    end else if (mode_reg[`M_LOADAR]) begin // RULE_01
      op_sel = OP_LOAD;
    end else if (mode_reg[`M_FULL]) begin
      op_sel = OP_FULL;
    end else if (mode_reg[`M_PARTIAL_RESET_CMD]) begin
      op_sel = OP_PARTIAL_RESET_CMD;
    end else if (mode_reg[`M_FULL_RESET_CMD]) begin
      op_sel = OP_FULL_RESET_CMD;
    end else if (mode_reg[`M_SHIP]) begin
      op_sel = OP_SHIP;
    end
  end
  // key taken, executed, then bits cleared
  always_comb begin
    case (state_reg)
      CMD_IDLE: state_next = take_key ? CMD_EXEC : CMD_IDLE;
      CMD_EXEC: state_next = CMD_DONE;
      CMD_DONE: state_next = CMD_IDLE;
      default:  state_next = CMD_IDLE;
    endcase
  end
  wire exec     = state_reg == CMD_EXEC;
  wire do_load  = exec && op_reg == OP_LOAD;
  wire do_full  = exec && op_reg == OP_FULL;
  wire do_partial_reset_cmd  = exec && op_reg == OP_PARTIAL_RESET_CMD;
  wire do_full_reset_cmd  = (exec && op_reg == OP_FULL_RESET_CMD) || init_reg;
  wire any_rst  = do_partial_reset_cmd || do_full_reset_cmd || ram_corrupt_i;
  wire hard_rst = do_full_reset_cmd || ram_corrupt_i;
  // ***************************************
  // derived values
  // ***************************************
  wire first_now = cell_voltage_pin_i <= first_thresh_i;
  wire final_now = cell_voltage_pin_i <= final_thresh_i;
  wire learn     = first_now && !first_empty_warning_reg && vdq_reg; // RULE_09 RULE_15
  wire [15:0] rate_comp_capacity_new = charging_state_bit_i ? nac_reg : // RULE_13
                         (rate_comp_new_i < rate_comp_capacity_reg ?
                          rate_comp_new_i : rate_comp_capacity_reg);
  wire [19:0] tcmp = {4'h0, initial_design_capacity_i, 8'h0} *
                     {16'h0, temp_gain_i} * {12'h0, temp_deficit_i} >> 2;
  wire [15:0] tcmp16 = (tcmp[19:16] != 4'h0) ? `SAT16 : tcmp[15:0];
  wire [15:0] thermal_comp_capacity_new = !temp_below_i ? rate_comp_capacity_reg : // RULE_14
                         (tcmp16 >= rate_comp_capacity_reg ? 16'h0 : rate_comp_capacity_reg - tcmp16);
  wire [15:0] lmd_gap = lmd_reg > nac_reg ? lmd_reg - nac_reg : 16'h0;
  wire [15:0] pct_q   = div_sat(`PCT_MUL * {16'h0, nac_reg},
                                lmd_reg); // RULE_11
  wire [16:0] si_twice = {initial_standby_i, 1'b0};
  wire si_window = avg_current_i > {12'h0, magnitude_filter_threshold_i} &&
                   {1'b0, avg_current_i} <= si_twice;
  wire [15:0] si_filt = si_reg - (si_reg >> 4) +
                        (avg_current_i >> 4); // RULE_19
  wire age_full = (age_reg + 16'h1) >= `AGE_LIMIT;
  wire [15:0] age_inc = age_reg + 16'h1;
  wire [15:0] life_inc = life_reg + 16'h1;
  wire [15:0] nac_up = (nac_reg == `SAT16) ? nac_reg : nac_reg + 16'h1;
  wire [15:0] nac_dn = (nac_reg == 16'h0) ? nac_reg : nac_reg - 16'h1;
  wire [7:0]  flags = {charging_state_bit_i, 2'b00, ci_reg, cal_reg,
                       vdq_reg, first_empty_warning_reg, final_empty_reg};
  // ***************************************
  // command engine and host writes
  // ***************************************
  // trigger clears on acceptance, mode command bits cleared after execution
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= CMD_IDLE;
      op_reg    <= OP_NONE;
      trig_reg  <= 8'h00;
      mode_reg  <= `MODE_RST;
      pred_reg  <= 16'h0;
      init_reg  <= 1'b1;
    end else begin
      state_reg <= state_next;
      init_reg  <= 1'b0;
      if (take_key) begin
        op_reg   <= op_sel; // RULE_02
        trig_reg <= 8'h00; // RULE_22
      end else if (host_wr_i && host_addr_i == `A_TRIG) begin
        trig_reg <= host_wdata_i;
      end
      if (state_reg == CMD_DONE) begin
        mode_reg <= mode_reg & `M_CLRMASK; // RULE_02
        trig_reg <= 8'h00;
      end else if (host_wr_i && host_addr_i == `A_MODE) begin
        mode_reg <= host_wdata_i;
      end
      if (host_wr_i && host_addr_i == `A_PRED) begin
        pred_reg[7:0] <= host_wdata_i;
      end
      if (host_wr_i && host_addr_i == `A_PRED + 7'h1) begin
        pred_reg[15:8] <= host_wdata_i;
      end
    end
  end
  // ***************************************
  // capacity registers
  // ***************************************
  // nominal and learned capacity survive a partial reset
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nac_reg <= 16'h0;
      lmd_reg <= 16'h0;
      ci_reg  <= 1'b1;
    end else if (hard_rst) begin
      nac_reg <= 16'h0;
      lmd_reg <= {initial_design_capacity_i, 8'h00};
      ci_reg  <= 1'b1; // RULE_06
    end else if (do_load) begin
      nac_reg <= pred_reg;
    end else if (do_full) begin
      nac_reg <= lmd_reg; // RULE_23
    end else if (!do_partial_reset_cmd) begin // RULE_24
      if (learn) begin
        lmd_reg <= measured_capacity_i; // RULE_15
        ci_reg  <= 1'b0; // RULE_06
      end else if (cycle_inc_i && age_full) begin
        ci_reg  <= 1'b1; // RULE_21
      end
      if (charge_count_i && !final_now) begin
        nac_reg <= nac_up; // RULE_12
      end else if (discharge_count_i) begin
        nac_reg <= nac_dn; // RULE_12
      end
    end
  end
  // ***************************************
  // flags and counters
  // ***************************************
  // all four flags drop on any reset
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cal_reg  <= 1'b0;
      vdq_reg  <= 1'b0;
      first_empty_warning_reg <= 1'b0;
      final_empty_reg <= 1'b0;
      age_reg  <= 16'h0;
      life_reg <= 16'h0;
    end else if (any_rst) begin
      cal_reg  <= 1'b0; // RULE_07
      vdq_reg  <= 1'b0; // RULE_08
      first_empty_warning_reg <= 1'b0; // RULE_10
      final_empty_reg <= 1'b0; // RULE_10
      age_reg  <= 16'h0;
      life_reg <= hard_rst ? 16'h0 : life_reg;
    end else begin
      if ((exec && op_reg == OP_CAL) || auto_cal_i) begin
        cal_reg <= 1'b1; // RULE_07
      end else if (cal_done_i) begin
        cal_reg <= 1'b0;
      end
      if (learn || learn_disqualify_i) begin
        vdq_reg <= 1'b0; // RULE_08
      end else if (learn_qualified_i) begin
        vdq_reg <= 1'b1;
      end
      first_empty_warning_reg <= first_now; // RULE_09
      final_empty_reg <= final_now; // RULE_10
      if (learn) begin
        age_reg <= 16'h0; // RULE_21
      end else if (cycle_inc_i) begin
        age_reg <= age_inc;
      end
      if (cycle_inc_i) begin
        life_reg <= life_inc;
      end
    end
  end
  // ***************************************
  // measurement and time registers
  // ***************************************
  // averages latch per period, times recompute every cycle
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avg_reg  <= 16'h0;
      si_reg   <= 16'h0;
      rate_comp_capacity_reg <= 16'h0;
      thermal_comp_capacity_reg <= 16'h0;
      temp_reg <= 16'h0;
      volt_reg <= 16'h0;
      tte_reg  <= `SAT16;
      ttf_reg  <= `SAT16;
      standby_time_to_empty_reg <= `SAT16;
      ptte_reg <= `SAT16;
      pct_reg  <= 8'h00;
      mli_reg  <= 16'h0;
      mltte_reg <= 16'h0;
      sae_reg  <= 16'h0;
    end else begin
      if (any_rst) begin
        si_reg <= initial_standby_i;
      end else if (avg_tick_i && si_window) begin
        si_reg <= si_filt; // RULE_19
      end
      if (avg_tick_i) begin
        avg_reg <= avg_current_i; // RULE_16
      end
      rate_comp_capacity_reg <= rate_comp_capacity_new;
      thermal_comp_capacity_reg <= thermal_comp_capacity_new;
      temp_reg <= temperature_i;
      volt_reg <= cell_voltage_pin_i;
      tte_reg  <= div_sat(`MIN_PER_H * {16'h0, thermal_comp_capacity_reg}, avg_reg); // RULE_17
      ttf_reg  <= div_sat(`TAPER_MUL * {16'h0, lmd_gap}, avg_reg); // RULE_18
      standby_time_to_empty_reg <= div_sat(`MIN_PER_H * {16'h0, nac_reg}, si_reg); // RULE_20
      ptte_reg <= div_sat(`MIN_PER_H * {16'h0, thermal_comp_capacity_reg}, pred_reg); // RULE_05
      pct_reg  <= (pct_q[15:8] != 8'h0) ? 8'hff : pct_q[7:0];
      mli_reg  <= max_load_current_i;
      mltte_reg <= max_load_tte_i;
      sae_reg  <= available_energy_i;
    end
  end
  // ***************************************
  // read mux
  // ***************************************
  wire       hi  = host_addr_i[0];
  wire [6:0] pa  = {host_addr_i[6:1], 1'b0};
  always_comb begin
    case (pa)
      `A_TRIG:  host_rdata_o = hi ? mode_reg : trig_reg;
      `A_PRED:  host_rdata_o = pick(pred_reg, hi);
      `A_PTTE:  host_rdata_o = pick(ptte_reg, hi);
      `A_TEMP:  host_rdata_o = pick(temp_reg, hi);
      `A_VOLT:  host_rdata_o = pick(volt_reg, hi);
      `A_FLAGS: host_rdata_o = hi ? pct_reg : flags;
      `A_NAC:   host_rdata_o = pick(nac_reg, hi);
      `A_RATE_COMP_CAPACITY:  host_rdata_o = pick(rate_comp_capacity_reg, hi);
      `A_THERMAL_COMP_CAPACITY:  host_rdata_o = pick(thermal_comp_capacity_reg, hi);
      `A_LMD:   host_rdata_o = pick(lmd_reg, hi);
      `A_AVG:   host_rdata_o = pick(avg_reg, hi);
      `A_TTE:   host_rdata_o = pick(tte_reg, hi);
      `A_TTF:   host_rdata_o = pick(ttf_reg, hi);
      `A_SI:    host_rdata_o = pick(si_reg, hi);
      `A_STANDBY_TIME_TO_EMPTY:  host_rdata_o = pick(standby_time_to_empty_reg, hi);
      `A_MLI:   host_rdata_o = pick(mli_reg, hi);
      `A_MLTTE: host_rdata_o = pick(mltte_reg, hi);
      `A_SAE:   host_rdata_o = pick(sae_reg, hi);
      `A_LEARNING_AGE_COUNT:  host_rdata_o = pick(age_reg, hi);
      `A_LIFETIME_DISCHARGE_COUNT:  host_rdata_o = pick(life_reg, hi);
      default:  host_rdata_o = 8'h00;
    endcase
  end
  // ***************************************
  // side outputs
  // ***************************************
  assign cal_start_o = exec && op_reg == OP_CAL;
  assign external_offset_measure_o = mode_reg[`M_CEO];
  assign ship_request_o = exec && op_reg == OP_SHIP;
  assign gpio_input_mode_o = mode_reg[`M_GPIO_IN];
  assign gpio_level_o = mode_reg[`M_GPIO_LVL];
endmodule

// ===== tb/gauge_host_register_bank_checker.sv
// port-level assertions for the gauge host register bank
`timescale 1ns/1ps
`include "gauge_defs.svh"
module gauge_host_register_bank_checker (
  input wire logic       mclk_i,
  input wire logic       resetn_i,
  input wire logic [6:0] host_addr_i,
  input wire logic       host_wr_i,
  input wire logic [7:0] host_wdata_i,
  input wire logic [7:0] host_rdata_o,
  input wire logic       cal_start_o,
  input wire logic       external_offset_measure_o,
  input wire logic       ship_request_o,
  input wire logic       gpio_input_mode_o,
  input wire logic       gpio_level_o
);
  // ******************************
  // decoded host writes
  // ******************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  wire trig_wr = host_wr_i && host_addr_i == `A_TRIG;
  wire key_a9  = trig_wr && host_wdata_i == `KEY_CMD;
  wire key_56  = trig_wr && host_wdata_i == `KEY_CAL;
  wire mode_wr = host_wr_i && host_addr_i == `A_MODE;
  // ******************************
  // assertions
  // ******************************
  trig_clear_a: assert property (key_a9 |=> host_addr_i != `A_TRIG || host_rdata_o == 8'h00)
    else $error("trigger byte not cleared after key");
  unmapped_zero_a: assert property (host_addr_i inside {[7'h30:7'h6d]} |-> host_rdata_o == 8'h00)
    else $error("unmapped address read not zero");
  mode_gpio_a: assert property (mode_wr |=> gpio_input_mode_o == $past(host_wdata_i[7])
    && gpio_level_o == $past(host_wdata_i[6]))
    else $error("gpio mode bits do not follow mode write");
  ext_follow_a: assert property (mode_wr |=> external_offset_measure_o == $past(host_wdata_i[5]))
    else $error("offset select does not follow mode write");
  gpio_keep_a: assert property ($changed(gpio_input_mode_o) |-> $past(mode_wr))
    else $error("gpio mode changed without mode write");
  cal_cause_a: assert property (cal_start_o |-> $past(key_56) || $past(key_56, 2)
    || $past(key_56, 3))
    else $error("calibration start without key");
  cal_launch_a: assert property (key_56 && external_offset_measure_o |-> ##[1:3] cal_start_o)
    else $error("calibration not started");
  ship_cause_a: assert property (ship_request_o |-> $past(key_a9) || $past(key_a9, 2)
    || $past(key_a9, 3))
    else $error("ship request without key");
  ship_pulse_a: assert property (ship_request_o |=> !ship_request_o)
    else $error("ship request longer than one cycle");
  mode_clear_a: assert property (key_a9 && external_offset_measure_o
    |-> ##[1:4] !external_offset_measure_o)
    else $error("command bits not cleared after command");
  // main scenarios reached
  key_seen_c: cover property (key_a9);
  cal_seen_c: cover property (cal_start_o);
  ship_seen_c: cover property (ship_request_o);
endmodule
bind gauge_host_register_bank gauge_host_register_bank_checker chk (.mclk_i, .resetn_i,
  .host_addr_i, .host_wr_i, .host_wdata_i, .host_rdata_o, .cal_start_o,
  .external_offset_measure_o, .ship_request_o, .gpio_input_mode_o, .gpio_level_o);

// ===== tb/gauge_host_model.sv
// host processor model issuing byte accesses to the register bank
`timescale 1ns/1ps
`include "gauge_defs.svh"
module gauge_host_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] host_rdata_i,
  output logic      [6:0] host_addr_o,
  output logic            host_wr_o,
  output logic      [7:0] host_wdata_o
);
  // idle bus at time zero
  initial begin
    host_addr_o = 7'h7f;
    host_wr_o = 1'b0;
    host_wdata_o = 8'h00;
  end
  // one byte write; released data shows its inverse
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    #1;
    host_addr_o = a;
    host_wdata_o = d;
    host_wr_o = 1'b1;
    @(posedge mclk_i);
    #1;
    host_wr_o = 1'b0;
    host_wdata_o = ~d;
  endtask
  // one byte read, taken at the edge
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    #1;
    host_addr_o = a;
    @(posedge mclk_i);
    d = host_rdata_i;
  endtask
  // low byte at even address, high byte next
  task automatic rd16(input logic [6:0] a, output logic [15:0] d);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a, lo);
    rd(a + 7'h01, hi);
    d = {hi, lo};
  endtask
  // mode bits first, then the key
  task automatic cmd(input logic [7:0] m, input logic [7:0] k);
    wr(`A_MODE, m);
    wr(`A_TRIG, k);
  endtask
endmodule

// ===== tb/gauge_host_register_bank_tb.sv
// self-checking bench of the gauge host register bank
`timescale 1ns/1ps
`include "gauge_defs.svh"
module gauge_host_register_bank_tb;
  import gauge_pkg::*;
  logic        mclk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        tick = 1'b0, chg = 1'b1, up = 1'b0, dn = 1'b0, tlo = 1'b0;
  logic        lq = 1'b0, ldq = 1'b0, cinc = 1'b0, acal = 1'b0, cdone = 1'b0, wr;
  logic [15:0] avg = 16'h0000, volt = 16'h1000, rcn = 16'h0000, fix = 16'h1234, v;
  logic [15:0] fth = 16'h0200, eth = 16'h0000;
  logic [3:0]  mft = 4'h0;
  logic        rc = 1'b0;
  logic [7:0]  rdata, wdata;
  logic [6:0]  addr;
  int          fail_count = 0, cmp_count = 0, cyc = 0;
  always #5 mclk_i = ~mclk_i;
  gauge_host_register_bank dut (.mclk_i, .resetn_i, .host_addr_i(addr), .host_wr_i(wr),
    .host_wdata_i(wdata), .host_rdata_o(rdata), .avg_tick_i(tick), .avg_current_i(avg),
    .temperature_i(fix), .cell_voltage_pin_i(volt), .first_thresh_i(fth),
    .final_thresh_i(eth), .charging_state_bit_i(chg), .charge_count_i(up),
    .discharge_count_i(dn), .rate_comp_new_i(rcn), .temp_below_i(tlo), .temp_gain_i(4'h1),
    .temp_deficit_i(8'h01), .initial_design_capacity_i(8'h04), .initial_standby_i(16'h0100),
    .magnitude_filter_threshold_i(mft), .learn_qualified_i(lq), .learn_disqualify_i(ldq),
    .measured_capacity_i(16'h0800), .cycle_inc_i(cinc), .auto_cal_i(acal),
    .cal_done_i(cdone), .ram_corrupt_i(rc), .max_load_current_i(fix),
    .max_load_tte_i(fix), .available_energy_i(fix), .cal_start_o(),
    .external_offset_measure_o(), .ship_request_o(), .gpio_input_mode_o(), .gpio_level_o());
  gauge_host_model host (.mclk_i, .host_rdata_i(rdata), .host_addr_o(addr),
    .host_wr_o(wr), .host_wdata_o(wdata));
  // ******************************
  // helpers
  // ******************************
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk16(input logic [6:0] a, input logic [15:0] e);
    host.rd16(a, v);
    chk(v, e);
  endtask
  task automatic chk8(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] b;
    host.rd(a, b);
    chk({8'h00, b}, {8'h00, e});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic pulse(ref logic s);
    step(1);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  // ******************************
  // scenarios
  // ******************************
  task automatic t_reset();
    chk8(`A_FLAGS, 8'h90);
    chk16(`A_LMD, 16'h0400);
    chk16(`A_SI, 16'h0100);
    chk8(`A_MODE, `MODE_RST);
    chk16(`A_TTE, `SAT16);
    chk16(`A_TEMP, fix);
    chk16(`A_VOLT, volt);
    chk16(`A_MLI, fix);
    chk16(`A_MLTTE, fix);
    chk16(`A_SAE, fix);
    host.wr(`A_FLAGS, 8'hff);
    chk8(`A_FLAGS, 8'h90);
    host.wr(`A_PRED, 8'h23);
    host.wr(`A_PRED + 7'h01, 8'h01);
    chk16(`A_PRED, 16'h0123);
    chk8(7'h40, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_full();
    host.cmd(8'h18, `KEY_CMD);
    chk8(`A_TRIG, 8'h00);
    step(4);
    chk16(`A_NAC, 16'h0400);
    chk8(`A_MODE, 8'h00);
    chk8(`A_RELATIVE_CHARGE_PCT, 8'h64);
    chk16(`A_STANDBY_TIME_TO_EMPTY, 16'h00f0);
    chk16(`A_TTE, `SAT16);
    avg = 16'h0010;
    pulse(tick);
    step(3);
    chk16(`A_SI, 16'h00f1);
    chk16(`A_AVG, 16'h0010);
    chk16(`A_TTE, 16'h0f00);
    repeat (16) pulse(dn);
    step(3);
    chk16(`A_NAC, 16'h03f0);
    chk16(`A_TTF, 16'h005a);
    chk16(`A_STANDBY_TIME_TO_EMPTY, 16'h00fa);
    chk16(`A_TTE, 16'h0ec4);
    chk8(`A_RELATIVE_CHARGE_PCT, 8'h62);
    pulse(up);
    step(2);
    chk16(`A_NAC, 16'h03f1);
    chk16(`A_PTTE, 16'h00d0);
    avg = 16'h0300;
    pulse(tick);
    chk16(`A_SI, 16'h00f1);
    mft = 4'hf;
    avg = 16'h000f;
    pulse(tick);
    chk16(`A_SI, 16'h00f1);
    $display("test capacity done");
  endtask
  task automatic t_rate();
    chg = 1'b0;
    rcn = 16'h0500;
    step(3);
    chk16(`A_RATE_COMP_CAPACITY, 16'h03f1);
    rcn = 16'h0300;
    step(3);
    chk16(`A_RATE_COMP_CAPACITY, 16'h0300);
    chk16(`A_THERMAL_COMP_CAPACITY, 16'h0300);
    tlo = 1'b1;
    step(3);
    chk16(`A_THERMAL_COMP_CAPACITY, 16'h0200);
    tlo = 1'b0;
    $display("test rate done");
  endtask
  task automatic t_learn();
    pulse(lq);
    chk8(`A_FLAGS, 8'h14);
    pulse(ldq);
    chk8(`A_FLAGS, 8'h10);
    pulse(lq);
    pulse(cinc);
    volt = 16'h0100;
    step(3);
    chk16(`A_LMD, 16'h0800);
    chk8(`A_FLAGS, 8'h02);
    chk16(`A_LEARNING_AGE_COUNT, 16'h0000);
    volt = 16'h0000;
    step(3);
    chk8(`A_FLAGS, 8'h03);
    volt = 16'h1000;
    $display("test learn done");
  endtask
  task automatic t_age();
    repeat (31) pulse(cinc);
    step(1);
    chk16(`A_LEARNING_AGE_COUNT, 16'h001f);
    chk8(`A_FLAGS, 8'h00);
    pulse(cinc);
    step(1);
    chk16(`A_LEARNING_AGE_COUNT, 16'h0020);
    chk8(`A_FLAGS, 8'h10);
    chk16(`A_LIFETIME_DISCHARGE_COUNT, 16'h0021);
    $display("test age done");
  endtask
  task automatic t_cmds();
    host.cmd(8'h30, `KEY_CMD);
    step(4);
    chk16(`A_NAC, 16'h0123);
    host.cmd(8'h0a, `KEY_CMD);
    step(4);
    chk16(`A_LMD, 16'h0800);
    chk16(`A_NAC, 16'h0123);
    chk8(`A_FLAGS, 8'h10);
    host.cmd(8'h02, `KEY_CMD);
    step(4);
    chk16(`A_LMD, 16'h0400);
    host.cmd(8'h20, `KEY_CAL);
    step(1);
    chk8(`A_FLAGS, 8'h18);
    pulse(cdone);
    chk8(`A_FLAGS, 8'h10);
    pulse(acal);
    chk8(`A_FLAGS, 8'h18);
    pulse(cdone);
    host.cmd(8'h10, `KEY_CAL);
    step(1);
    chk8(`A_FLAGS, 8'h18);
    pulse(cdone);
    host.cmd(8'hc1, `KEY_CMD);
    step(4);
    chk8(`A_MODE, 8'hc0);
    pulse(up);
    eth = 16'h2000;
    pulse(up);
    step(1);
    chk16(`A_NAC, 16'h0001);
    pulse(rc);
    step(1);
    chk16(`A_NAC, 16'h0000);
    $display("test commands done");
  endtask
  // ******************************
  // run control
  // ******************************
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    #1;
    resetn_i = 1'b1;
    t_reset();
    t_full();
    t_rate();
    t_learn();
    t_age();
    t_cmds();
    stop_test();
  end
endmodule
